// >>> src/bldc_pkg.sv
/*
  Constants, field layouts and carrier types for the sensorless BLDC
  commutation sequencer.
  Assumes one 40 MHz core clock and an external hysteretic comparator per
  phase.
*/
// Behaviour
// - six commutation states, stepped in fixed cyclic order once per point
// - high-side gate low means FET on, low-side gate high means on
// - states 1..6 drive AC, BC, BA, CA, CB, AB; third phase floats
// - motor-enable clear: all FETs off, no commutation, overrides everything
// - reverse bit 0 increments the state, 1 decrements it
// - enabled, braking, PWM idle past brake time: all low-sides on
// - serial word selects speed output style, cycle rate by default
// - cycle mode: speed output high entering state 1, low entering 4
// - commutation mode: square wave, falling edge at each commutation
// - undriven phase comparator result is digitally filtered
// - crossings accepted during both PWM on and off time
// - expect crossing mid period; adjust phase and period to cut error
// - 4-bit advance field delays expected crossing, up to 28 degrees
// - PI correction with separate 4-bit proportional and integral gains
// - missing crossing: keep commutating, change rate by proportional term
// - no crossings: lower commutation frequency at every point
// - speed below quarter of start speed: loss of sync, stop
// - speed above ratio times max speed: loss of sync
// - max speed field sets 100% target and feeds overspeed threshold; only the overspeed check uses it here
// - serial words are 16 bits, msb first, sampled on rising clock
// - strobe low shows fault flag, diagnostic bit 15, on serial out
// - strobe high ignores clock and data, serial out released
// - fault output open drain, pulled low when active
package bldc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BRAKE_TIME_US = 100;
  localparam int unsigned BRAKE_CYCLES = BRAKE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILT_LEN = 8;
  localparam int unsigned PW = 24;
  // cycles per commutation for one start-speed / max-speed step
  localparam logic [23:0] START_UNIT = 24'h000FA0;
  localparam logic [23:0] MAXSPD_UNIT = 24'h000200;

  // ==========================================================
  // serial word layout: [15:14] selects the target group
  localparam int unsigned SER_BITS = 16;
  localparam int unsigned SEL_HI = 15;
  localparam int unsigned SEL_LO = 14;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_LOOP = 2'h1;
  localparam logic [1:0] SEL_SPEED = 2'h2;
  localparam int unsigned DIAG_FAULT = 15;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_1 = 3'b001, ST_2 = 3'b010, ST_3 = 3'b011,
    ST_4 = 3'b100, ST_5 = 3'b101, ST_6 = 3'b110
  } comm_state_t;

  typedef struct packed {
    logic run;
    logic dir;
    logic brake_select;
    logic speed_mode;  // 0 cycle rate, 1 commutation rate
  } ctrl_t;

  typedef struct packed {
    logic [3:0] phase_advance_field;
    logic [3:0] prop_gain_field;
    logic [3:0] integ_gain_field;
  } loop_cfg_t;

  typedef struct packed {
    logic [3:0] start_speed_field;
    logic [1:0] overspeed_ratio_field;
    logic [2:0] max_speed_field;
  } speed_cfg_t;

  typedef struct packed {
    logic [2:0] hi_n;  // c,b,a: 0 turns the P-FET on
    logic [2:0] lo;    // c,b,a: 1 turns the N-FET on
  } gate_t;

  // reset values
  localparam ctrl_t CTRL_RST = 4'h0;
  localparam loop_cfg_t LOOP_RST = 12'h084;
  localparam speed_cfg_t SPEED_RST = 9'h10C;
  localparam gate_t GATE_OFF = 6'h38;
endpackage : bldc_pkg

// >>> src/bldc_commutation.sv
/*
  Sensorless six-state commutation sequencer with serial settings port.
  Assumes all inputs synchronous to core_clk_i, comparator outputs on the
  phase sense inputs, and open-drain pins resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module bldc_commutation (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // phase comparators and pwm status
  input wire logic phase_sense_a_i,
  input wire logic phase_sense_b_i,
  input wire logic phase_sense_c_i,
  input wire logic pwm_active_i,
  // serial port
  input wire logic serial_clk_i,
  input wire logic serial_strobe_low_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // gate drive
  output logic hiside_gate_a_o,
  output logic hiside_gate_b_o,
  output logic hiside_gate_c_o,
  output logic loside_gate_a_o,
  output logic loside_gate_b_o,
  output logic loside_gate_c_o,
  // open-drain indicators, enable low pulls the pin low
  output logic speed_output_oe_n_o,
  output logic fault_out_low_oe_n_o
);
  // ==========================================================
  // state
  localparam int EW = bldc_pkg::PW + 2;
  bldc_pkg::ctrl_t ctrl_ff, nxt_ctrl;
  bldc_pkg::loop_cfg_t loop_ff, nxt_loop;
  bldc_pkg::speed_cfg_t spd_cfg_ff, nxt_spd_cfg;
  logic sclk_q_ff, nxt_sclk_q, strobe_q_ff, nxt_strobe_q;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic [15:0] sh_in_ff, nxt_sh_in, sh_out_ff, nxt_sh_out;
  logic sdo_oe_n_ff, nxt_sdo_oe_n;
  bldc_pkg::comm_state_t state_ff, nxt_state;
  logic [bldc_pkg::PW-1:0] period_ff, nxt_period, timer_ff, nxt_timer;
  logic [bldc_pkg::PW-1:0] zc_time_ff, nxt_zc_time;
  logic signed [EW-1:0] integ_ff, nxt_integ;
  logic zc_seen_ff, nxt_zc_seen, filt_ff, nxt_filt;
  logic [2:0] fcnt_ff, nxt_fcnt;
  logic lost_ff, nxt_lost, spd_ff, nxt_spd, fault_n_ff, nxt_fault_n;
  logic [11:0] idle_cnt_ff, nxt_idle_cnt;
  bldc_pkg::gate_t gate_ff, nxt_gate;
  logic comm_ev, braking, running, raw;
  logic [bldc_pkg::PW-1:0] start_per, max_per;
  logic signed [EW-1:0] err, expected;

  // ==========================================================
  // helpers
  function automatic bldc_pkg::comm_state_t step(
      input bldc_pkg::comm_state_t s, input logic rev);
    logic [2:0] v;
    v = s;
    if (!rev) begin
      v = (v == 3'h6) ? 3'h1 : v + 3'h1;
    end else begin
      v = (v == 3'h1) ? 3'h6 : v - 3'h1;
    end
    return bldc_pkg::comm_state_t'(v);
  endfunction : step

  // scale a signed error by a 4-bit gain, then shift down
  function automatic logic signed [EW-1:0] gain(
      input logic signed [EW-1:0] e, input logic [3:0] g, input int sh);
    logic signed [EW+4:0] p;
    p = e * $signed({1'b0, g});
    return EW'(p >>> sh);
  endfunction : gain

  // ==========================================================
  // serial port: settings in, diagnostic word out
  always_comb begin
    nxt_sclk_q = serial_clk_i;
    nxt_strobe_q = serial_strobe_low_i;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_sh_in = sh_in_ff;
    nxt_sh_out = sh_out_ff;
    nxt_sdo_oe_n = serial_strobe_low_i;
    nxt_ctrl = ctrl_ff;
    nxt_loop = loop_ff;
    nxt_spd_cfg = spd_cfg_ff;
    if (serial_strobe_low_i) begin
      // idle: bus ignored, fault flag parked at msb for the next frame
      nxt_bit_cnt = 5'h00;
      nxt_sh_out = {lost_ff, 3'(state_ff), 12'h000};
      // apply only a complete word; short or long frames are dropped
      if (!strobe_q_ff && bit_cnt_ff == 5'(bldc_pkg::SER_BITS)) begin
        unique case (sh_in_ff[bldc_pkg::SEL_HI:bldc_pkg::SEL_LO])
          bldc_pkg::SEL_CTRL: nxt_ctrl = sh_in_ff[3:0];
          bldc_pkg::SEL_LOOP: nxt_loop = sh_in_ff[11:0];
          bldc_pkg::SEL_SPEED: nxt_spd_cfg = sh_in_ff[8:0];
          default: ;
        endcase
      end
    end else if (serial_clk_i && !sclk_q_ff) begin
      nxt_sh_in = {sh_in_ff[14:0], serial_in_i};
      nxt_sh_out = {sh_out_ff[14:0], 1'b0};
      if (bit_cnt_ff != 5'h1F) begin
        nxt_bit_cnt = bit_cnt_ff + 5'h01;
      end
    end
  end

  // registers of the serial port
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q_ff <= 1'b1;
      strobe_q_ff <= 1'b1;
      bit_cnt_ff <= 5'h00;
      sh_in_ff <= 16'h0000;
      sh_out_ff <= 16'h0000;
      sdo_oe_n_ff <= 1'b1;
      ctrl_ff <= bldc_pkg::CTRL_RST;
      loop_ff <= bldc_pkg::LOOP_RST;
      spd_cfg_ff <= bldc_pkg::SPEED_RST;
    end else if (clk_en_i) begin
      sclk_q_ff <= nxt_sclk_q;
      strobe_q_ff <= nxt_strobe_q;
      bit_cnt_ff <= nxt_bit_cnt;
      sh_in_ff <= nxt_sh_in;
      sh_out_ff <= nxt_sh_out;
      sdo_oe_n_ff <= nxt_sdo_oe_n;
      ctrl_ff <= nxt_ctrl;
      loop_ff <= nxt_loop;
      spd_cfg_ff <= nxt_spd_cfg;
    end
  end

  // ==========================================================
  // commutation controller
  assign start_per = 24'(bldc_pkg::START_UNIT
                         * (5'h10 - {1'b0, spd_cfg_ff.start_speed_field}));
  assign max_per = 24'(bldc_pkg::MAXSPD_UNIT
                       * (4'h8 - {1'b0, spd_cfg_ff.max_speed_field}));
  assign braking = ctrl_ff.brake_select
                   && idle_cnt_ff == 12'(bldc_pkg::BRAKE_CYCLES);
  assign running = ctrl_ff.run && !lost_ff && !braking;
  assign comm_ev = running && timer_ff >= period_ff - 24'h000001;
  // advance of 1/32 period per field step, 0..28 degrees of a 60 degree step
  assign expected = EW'({2'b00, period_ff >> 1})
                    + gain(EW'({2'b00, period_ff >> 5}),
                           loop_ff.phase_advance_field, 0);
  assign err = EW'({2'b00, zc_time_ff}) - expected;

  // comparator of the floating phase; the external reference tracks the
  // bridge levels, so no pwm-phase gating is needed here
  always_comb begin
    unique case (state_ff)
      bldc_pkg::ST_2, bldc_pkg::ST_5: raw = phase_sense_a_i;
      bldc_pkg::ST_1, bldc_pkg::ST_4: raw = phase_sense_b_i;
      default: raw = phase_sense_c_i;
    endcase
  end

  // next values of sequencer, filter and loop
  always_comb begin
    logic signed [EW-1:0] np;
    np = '0;
    nxt_state = state_ff;
    nxt_period = period_ff;
    nxt_timer = timer_ff;
    nxt_zc_time = zc_time_ff;
    nxt_integ = integ_ff;
    nxt_zc_seen = zc_seen_ff;
    nxt_filt = filt_ff;
    nxt_fcnt = 3'h0;
    nxt_lost = lost_ff;
    nxt_spd = spd_ff;
    nxt_idle_cnt = pwm_active_i ? 12'h000 : idle_cnt_ff;
    if (!pwm_active_i && !braking) begin
      nxt_idle_cnt = idle_cnt_ff + 12'h001;
    end
    if (!ctrl_ff.run) begin
      // coasting: restart cleanly from the start speed
      nxt_state = bldc_pkg::ST_1;
      nxt_period = start_per;
      nxt_timer = '0;
      nxt_integ = '0;
      nxt_lost = 1'b0;
      nxt_zc_seen = 1'b0;
    end else if (running) begin
      nxt_timer = timer_ff + 24'h000001;
      // a change must persist FILT_LEN samples to count as a crossing
      if (raw != filt_ff) begin
        nxt_fcnt = fcnt_ff + 3'h1;
        if (fcnt_ff == 3'(bldc_pkg::FILT_LEN - 1)) begin
          nxt_filt = raw;
          nxt_fcnt = 3'h0;
          if (!zc_seen_ff) begin
            nxt_zc_seen = 1'b1;
            nxt_zc_time = timer_ff;
          end
        end
      end
      // a start from coast enters state 1 as well, so cycle mode rises here
      if (!spd_ff && (ctrl_ff.speed_mode ? timer_ff == period_ff >> 1
          : state_ff == bldc_pkg::ST_1 && timer_ff == '0)) begin
        nxt_spd = 1'b1;
      end
      if (comm_ev) begin
        nxt_state = step(state_ff, ctrl_ff.dir);
        nxt_timer = '0;
        nxt_zc_seen = 1'b0;
        nxt_filt = nxt_state inside {bldc_pkg::ST_2, bldc_pkg::ST_5}
                   ? phase_sense_a_i
                   : nxt_state inside {bldc_pkg::ST_1, bldc_pkg::ST_4}
                   ? phase_sense_b_i : phase_sense_c_i;
        if (zc_seen_ff) begin
          nxt_integ = integ_ff
                      + gain(err, loop_ff.integ_gain_field, 6);
          np = EW'({2'b00, period_ff})
               + gain(err, loop_ff.prop_gain_field, 4) + nxt_integ;
        end else begin
          // no crossing: only the proportional step, always slower
          np = EW'({2'b00, period_ff}) + EW'(1)
               + gain(EW'({2'b00, period_ff >> 3}),
                      loop_ff.prop_gain_field, 4);
        end
        if (np < EW'(1)) begin
          np = EW'(1);
        end else if (np > EW'({2'b00, {bldc_pkg::PW{1'b1}}})) begin
          np = EW'({2'b00, {bldc_pkg::PW{1'b1}}});
        end
        nxt_period = np[bldc_pkg::PW-1:0];
        if (28'(nxt_period) > 28'(start_per) * 28'h4) begin
          nxt_lost = 1'b1;
        end
        if (28'(nxt_period)
            * (28'(spd_cfg_ff.overspeed_ratio_field) + 28'h0000005)
            < 28'(max_per) * 28'h4) begin
          nxt_lost = 1'b1;
        end
        if (ctrl_ff.speed_mode) begin
          nxt_spd = 1'b0;
        end else if (nxt_state == bldc_pkg::ST_1) begin
          nxt_spd = 1'b1;
        end else if (nxt_state == bldc_pkg::ST_4) begin
          nxt_spd = 1'b0;
        end
      end
    end
    nxt_fault_n = !nxt_lost;
  end

  // gate pattern; shoot-through is avoided since no state turns on both FETs of one phase
  always_comb begin
    nxt_gate = bldc_pkg::GATE_OFF;
    if (ctrl_ff.run && braking) begin
      nxt_gate.lo = 3'h7;
    end else if (running) begin
      unique case (state_ff)
        bldc_pkg::ST_1: nxt_gate = {3'b110, 3'b100};
        bldc_pkg::ST_2: nxt_gate = {3'b101, 3'b100};
        bldc_pkg::ST_3: nxt_gate = {3'b101, 3'b001};
        bldc_pkg::ST_4: nxt_gate = {3'b011, 3'b001};
        bldc_pkg::ST_5: nxt_gate = {3'b011, 3'b010};
        bldc_pkg::ST_6: nxt_gate = {3'b110, 3'b010};
        default: nxt_gate = bldc_pkg::GATE_OFF;
      endcase
    end
  end

  // registers of the sequencer
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= bldc_pkg::ST_1;
      period_ff <= bldc_pkg::START_UNIT;
      timer_ff <= '0;
      zc_time_ff <= '0;
      integ_ff <= '0;
      zc_seen_ff <= 1'b0;
      filt_ff <= 1'b0;
      fcnt_ff <= 3'h0;
      lost_ff <= 1'b0;
      spd_ff <= 1'b0;
      fault_n_ff <= 1'b1;
      idle_cnt_ff <= 12'h000;
      gate_ff <= bldc_pkg::GATE_OFF;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      period_ff <= nxt_period;
      timer_ff <= nxt_timer;
      zc_time_ff <= nxt_zc_time;
      integ_ff <= nxt_integ;
      zc_seen_ff <= nxt_zc_seen;
      filt_ff <= nxt_filt;
      fcnt_ff <= nxt_fcnt;
      lost_ff <= nxt_lost;
      spd_ff <= nxt_spd;
      fault_n_ff <= nxt_fault_n;
      idle_cnt_ff <= nxt_idle_cnt;
      gate_ff <= nxt_gate;
    end
  end

  // outputs
  assign {hiside_gate_c_o, hiside_gate_b_o, hiside_gate_a_o} = gate_ff.hi_n;
  assign {loside_gate_c_o, loside_gate_b_o, loside_gate_a_o} = gate_ff.lo;
  assign serial_out_o = sh_out_ff[bldc_pkg::DIAG_FAULT];
  assign serial_out_oe_n_o = sdo_oe_n_ff;
  assign speed_output_oe_n_o = spd_ff;
  assign fault_out_low_oe_n_o = fault_n_ff;

  // ==========================================================
  // checks
  a_coast_gates_off: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && !ctrl_ff.run) |=>
    (gate_ff == bldc_pkg::GATE_OFF)) else $error("coast not all off");
  a_one_pair_on: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) ($past(running) && $past(clk_en_i)) |->
    ($countones(~gate_ff.hi_n) == 1 && $countones(gate_ff.lo) == 1
     && (~gate_ff.hi_n & gate_ff.lo) == 3'h0)) else $error("bad pair");
  a_fwd_step: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev && !ctrl_ff.dir) |=>
    (state_ff == step($past(state_ff), 1'b0))) else $error("fwd step");
  a_rev_step: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev && ctrl_ff.dir) |=>
    (state_ff == step($past(state_ff), 1'b1))) else $error("rev step");
  a_brake_lowside: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && ctrl_ff.run && braking) |=>
    (gate_ff.lo == 3'h7 && gate_ff.hi_n == 3'h7)) else $error("brake");
  a_sdo_release: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && serial_strobe_low_i) |=>
    serial_out_oe_n_o) else $error("sdo driven while idle");
  a_sdo_fault: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) ($past(clk_en_i) && strobe_q_ff
    && !serial_strobe_low_i) |-> (serial_out_o == $past(lost_ff)))
    else $error("fault bit not shown");
  a_timer_clear: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev) |=> (timer_ff == '0))
    else $error("timer not cleared");
  a_cycle_high: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev && !ctrl_ff.speed_mode
    && nxt_state == bldc_pkg::ST_1) |=> speed_output_oe_n_o)
    else $error("cycle signal not high");
  a_commutation_rate_signal_fall: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev && ctrl_ff.speed_mode)
    |=> !speed_output_oe_n_o) else $error("commutation_rate_signal not low");
  a_lowspeed: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (clk_en_i && comm_ev
    && 28'(nxt_period) > 28'(start_per) * 28'h4) |=> lost_ff ##1
    !fault_out_low_oe_n_o) else $error("low speed missed");
endmodule : bldc_commutation
`default_nettype wire

// >>> test/bldc_bridge_model.sv
/*
  Behavioural model of the external complementary bridge and stalled motor.
  Assumes registered gate outputs sampled on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module bldc_bridge_model (
  // clock
  input wire logic core_clk_i,
  // gate drive, index 0 is phase a
  input wire logic [2:0] hi_n_i,
  input wire logic [2:0] lo_i,
  // comparator results
  output logic phase_sense_a_o,
  output logic phase_sense_b_o,
  output logic phase_sense_c_o,
  // illegal bridge states seen
  output int unsigned illegal_count_o
);
  logic [2:0] hi_on;
  int unsigned n_hi;
  int unsigned n_lo;
  int unsigned bad_legs = 0;
  // ==========================================================
  // leg decoding: a p-fet conducts while its gate is low
  always_comb begin
    hi_on = ~hi_n_i;
    n_hi = $countones(hi_on);
    n_lo = $countones(lo_i);
  end
  // stalled rotor gives no bemf, so no crossing is ever seen and the
  // sequencer has to slow down on its own
  assign phase_sense_a_o = 1'b0;
  assign phase_sense_b_o = 1'b0;
  assign phase_sense_c_o = 1'b0;
  // ==========================================================
  // legal: coast, brake, or one leg high with another leg low
  // sampled mid-cycle, where the registered gates are settled
  assign illegal_count_o = bad_legs;
  always @(negedge core_clk_i) begin
    if ((hi_on & lo_i) != 3'h0) begin
      bad_legs <= bad_legs + 1;
    end else if (!((n_hi == 0 && (n_lo == 0 || n_lo == 3)) ||
                   (n_hi == 1 && n_lo == 1))) begin
      bad_legs <= bad_legs + 1;
    end
  end
endmodule : bldc_bridge_model
`default_nettype wire

// >>> test/bldc_commutation_test.sv
/*
  Self-checking bench for the commutation sequencer.
  Assumes the bridge model beside it and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value at %0t: %s", $time, m); end end
module bldc_commutation_test;
  logic core_clk_i, sys_rst_i, clk_en_i, pwm_active_i;
  logic serial_clk_i, serial_strobe_low_i, serial_in_i;
  logic serial_out_o, serial_out_oe_n_o, spd_oe_n, flt_oe_n;
  logic hg_a, hg_b, hg_c, lg_a, lg_b, lg_c, sns_a, sns_b, sns_c;
  logic pb;
  logic [5:0] gv;
  int unsigned illegal;
  int bad_count, total_checks;
  // open-drain pins with pull-ups: released reads high
  assign gv = {hg_c, hg_b, hg_a, lg_c, lg_b, lg_a};
  wire logic speed_pin = spd_oe_n ? 1'b1 : 1'b0;
  wire logic fault_pin = flt_oe_n ? 1'b1 : 1'b0;
  // ==========================================================
  // device and bridge
  bldc_commutation dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .phase_sense_a_i(sns_a), .phase_sense_b_i(sns_b),
    .phase_sense_c_i(sns_c), .pwm_active_i(pwm_active_i),
    .serial_clk_i(serial_clk_i), .serial_strobe_low_i(serial_strobe_low_i),
    .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_n_o(serial_out_oe_n_o), .hiside_gate_a_o(hg_a),
    .hiside_gate_b_o(hg_b), .hiside_gate_c_o(hg_c), .loside_gate_a_o(lg_a),
    .loside_gate_b_o(lg_b), .loside_gate_c_o(lg_c),
    .speed_output_oe_n_o(spd_oe_n), .fault_out_low_oe_n_o(flt_oe_n));
  bldc_bridge_model bridge (.core_clk_i(core_clk_i), .hi_n_i(gv[5:3]),
    .lo_i(gv[2:0]), .phase_sense_a_o(sns_a), .phase_sense_b_o(sns_b),
    .phase_sense_c_o(sns_c), .illegal_count_o(illegal));
  // 40 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // helpers; inputs only move at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // expected gates of state s: one high leg, one low leg
  function automatic logic [5:0] pat(input int s);
    int hi[6] = '{0, 1, 1, 2, 2, 0};
    int lo[6] = '{2, 2, 0, 0, 1, 1};
    bldc_pkg::gate_t g;
    g.hi_n = ~(3'h1 << hi[s-1]);
    g.lo = 3'h1 << lo[s-1];
    return g;
  endfunction : pat
  // one frame, msb first; the clock is high at both strobe edges
  task automatic frame(input logic [15:0] w, input int nb,
                       output logic [15:0] d);
    d = 16'h0000;
    serial_strobe_low_i = 1'b0;
    cyc(3);
    `CHK(serial_out_oe_n_o, 1'b0, "serial out not driven")
    for (int i = 15; i > 15 - nb; i--) begin
      d[i] = serial_out_o;
      serial_clk_i = 1'b0;
      serial_in_i = w[i];
      cyc(3);
      serial_clk_i = 1'b1;
      cyc(3);
    end
    serial_strobe_low_i = 1'b1;
    cyc(3);
    `CHK(serial_out_oe_n_o, 1'b1, "serial out not released")
  endtask : frame
  // wait for the next commutation, bounded, and count its interval
  task automatic step(input int s, output int n);
    logic [5:0] g0;
    g0 = gv;
    n = 0;
    while (gv === g0 && n < 20000) begin
      if (speed_pin) pb = 1'b1;
      cyc(1);
      n++;
    end
    `CHK(gv, pat(s), "wrong commutation state")
  endtask : step
  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK(gv, bldc_pkg::GATE_OFF, "bridge on at reset")
    `CHK(serial_out_oe_n_o, 1'b1, "serial out driven")
    `CHK(fault_pin, 1'b1, "fault pin low at reset")
  endtask : t_reset
  // fastest start speed keeps the run short: 4000 cycles for the first step
  task automatic t_fwd();
    int n1, n2, n3;
    logic [15:0] d;
    frame({bldc_pkg::SEL_SPEED, 14'h01EC}, 16, d);
    `CHK(d[15], 1'b0, "fault flag set")
    frame({bldc_pkg::SEL_CTRL, 14'h0008}, 16, d);
    cyc(2);
    `CHK(gv, pat(1), "not in state 1")
    `CHK(speed_pin, 1'b1, "cycle signal low in state 1")
    step(2, n1);
    `CHK(n1 > 3900 && n1 < 4400, 1'b1, "first period")
    step(3, n2);
    `CHK(n2 > n1, 1'b1, "no slow down")
    `CHK(speed_pin, 1'b1, "cycle signal low in state 3")
    step(4, n3);
    `CHK(n3 > n2, 1'b1, "no slow down")
    cyc(2);
    `CHK(speed_pin, 1'b0, "cycle signal high in state 4")
    frame(16'hC000, 16, d);
    `CHK(d[14:12], 3'h4, "diag state")
    `CHK(gv, pat(4), "ignored word acted")
    `CHK(fault_pin, 1'b1, "fault without cause")
  endtask : t_fwd
  // short frame and strobe-high activity must both leave the motor running
  task automatic t_refuse();
    logic [15:0] d;
    frame(16'h0000, 15, d);
    cyc(2);
    `CHK(gv, pat(4), "short frame applied")
    for (int i = 0; i < 16; i++) begin
      serial_in_i = i[0];
      serial_clk_i = 1'b0;
      cyc(2);
      serial_clk_i = 1'b1;
      cyc(2);
    end
    `CHK(gv, pat(4), "strobe high frame applied")
    `CHK(serial_out_oe_n_o, 1'b1, "serial out driven while idle")
  endtask : t_refuse
  task automatic t_rev();
    int n;
    logic [15:0] d;
    frame({bldc_pkg::SEL_CTRL, 14'h000D}, 16, d);
    step(3, n);
    `CHK(gv, pat(3), "no decrement")
    cyc(2);
    `CHK(speed_pin, 1'b0, "rate signal high after step")
    pb = 1'b0;
    step(2, n);
    `CHK(pb, 1'b1, "rate signal never high")
    cyc(2);
    `CHK(speed_pin, 1'b0, "no fall at step")
  endtask : t_rev
  task automatic t_brake();
    logic [15:0] d;
    frame({bldc_pkg::SEL_CTRL, 14'h000F}, 16, d);
    pwm_active_i = 1'b0;
    cyc(bldc_pkg::BRAKE_CYCLES - 50);
    `CHK(gv === 6'h3F, 1'b0, "brake too early")
    // clock enable low must freeze the brake timer as well
    clk_en_i = 1'b0;
    cyc(200);
    `CHK(gv === 6'h3F, 1'b0, "brake timer ran while frozen")
    clk_en_i = 1'b1;
    cyc(100);
    `CHK(gv, 6'h3F, "no brake")
    cyc(6000);
    `CHK(gv, 6'h3F, "commutation while braking")
  endtask : t_brake
  // run clear must win over brake still selected
  task automatic t_stop();
    logic [15:0] d;
    frame({bldc_pkg::SEL_CTRL, 14'h0002}, 16, d);
    cyc(2);
    `CHK(gv, bldc_pkg::GATE_OFF, "bridge not off")
    cyc(500);
    `CHK(gv, bldc_pkg::GATE_OFF, "bridge moved")
    `CHK(illegal, 0, "illegal bridge state")
  endtask : t_stop
  // ==========================================================
  // verdict, run end and watchdog
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // run needs about 34000 cycles; the limit leaves margin for slow steps
  initial begin
    repeat (70000) @(posedge core_clk_i);
    bad_count++;
    $display("wrong value at %0t: %s", $time, "watchdog expired");
    wrap_up();
  end
  initial begin
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    pwm_active_i = 1'b1;
    serial_clk_i = 1'b1;
    serial_strobe_low_i = 1'b1;
    serial_in_i = 1'b0;
    pb = 1'b0;
    bad_count = 0;
    total_checks = 0;
    cyc(10);
    sys_rst_i = 1'b0;
    cyc(2);
    t_reset();
    t_fwd();
    t_refuse();
    t_rev();
    t_brake();
    t_stop();
    wrap_up();
  end
endmodule : bldc_commutation_test
`default_nettype wire
